// file: verilog/wdrs_supervisor.sv
/*
  Wake-up, watchdog and reset supervisor of a low-dropout regulator.
  Assumes synchronous supply flags from the analog comparators and a
  synchronous watchdog service input from the sleeping controller.
*/
`timescale 1ns/10ps
`default_nettype none
module wdrs_supervisor #(
  parameter int unsigned WAKE_PERIOD_CYC = wdrs_pkg::WAKE_PERIOD_CYC,
  parameter int unsigned RST_DELAY_CYC = wdrs_pkg::RST_DELAY_CYC,
  parameter int unsigned RST_TO_WAKE_CYC = wdrs_pkg::RST_TO_WAKE_CYC,
  parameter int unsigned BLANK_CYC = wdrs_pkg::BLANK_CYC,
  parameter int unsigned MIN_PULSE_CYC = wdrs_pkg::MIN_PULSE_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire wdrs_pkg::wdrs_supply_s supply_i,
  input wire logic watchdog_service_input_i,
  output logic reset_n_o,
  output logic wake_o
);

  localparam int CW = 32;
  localparam logic [CW-1:0] HALF = CW'(WAKE_PERIOD_CYC / 2);
  localparam logic [CW-1:0] PERIOD = CW'(WAKE_PERIOD_CYC);
  localparam logic [CW-1:0] DLY = CW'(RST_DELAY_CYC);
  localparam logic [CW-1:0] FIRST = CW'(RST_TO_WAKE_CYC);
  localparam logic [CW-1:0] BLANK = CW'(BLANK_CYC);

  wdrs_pkg::wdrs_state_e state_ff;
  logic [CW-1:0] dly_cnt_ff;
  logic [CW-1:0] ph_cnt_ff;
  logic first_ff;
  logic served_ff;
  logic wake_ff;
  logic reset_n_ff;
  logic wdi_fall;
  logic hard_cause;
  logic period_end;
  logic missed;
  logic accept;
  logic [CW-1:0] hi_cnt_ff;

  wdrs_wdi_qual #(
    .MIN_CYC(MIN_PULSE_CYC)
  ) u_qual (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .watchdog_service_input_i(watchdog_service_input_i),
    .fall_o(wdi_fall)
  );

  // Low supply wins over every other cause except enable low (shutdown)
  assign hard_cause = supply_i.vin_low || supply_i.regulated_output_voltage_uv ||
                      !supply_i.regulated_output_voltage_in_reg;

  // The first segment after release is the rise delay, then full periods
  assign period_end = (state_ff == wdrs_pkg::WDRS_RUN) &&
                      (first_ff ? (ph_cnt_ff == FIRST - CW'(1))
                                : (ph_cnt_ff == PERIOD - CW'(1)));
  assign missed = period_end && !first_ff && !served_ff && !accept;
  assign accept = (state_ff == wdrs_pkg::WDRS_RUN) && !first_ff &&
                  wdi_fall && !served_ff &&
                  (ph_cnt_ff >= BLANK);

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      state_ff <= wdrs_pkg::WDRS_OFF;
      dly_cnt_ff <= '0;
    end
    else if (!supply_i.enable)
      state_ff <= wdrs_pkg::WDRS_OFF;
    else if (hard_cause)
      state_ff <= wdrs_pkg::WDRS_HOLD;
    else
    begin
      unique case (state_ff)
        wdrs_pkg::WDRS_OFF,
        wdrs_pkg::WDRS_HOLD:
        begin
          state_ff <= wdrs_pkg::WDRS_DELAY;
          dly_cnt_ff <= '0;
        end
        wdrs_pkg::WDRS_DELAY:
        begin
          if (dly_cnt_ff >= DLY - CW'(1))
            state_ff <= wdrs_pkg::WDRS_RUN;
          else
            dly_cnt_ff <= dly_cnt_ff + CW'(1);
        end
        wdrs_pkg::WDRS_RUN:
        begin
          if (missed)
          begin
            state_ff <= wdrs_pkg::WDRS_DELAY;
            dly_cnt_ff <= '0;
          end
        end
      endcase
    end
  end

  // Phase counter restarts on every reset release
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || state_ff != wdrs_pkg::WDRS_RUN)
    begin
      ph_cnt_ff <= '0;
      first_ff <= 1'b1;
      served_ff <= 1'b0;
    end
    else if (period_end)
    begin
      ph_cnt_ff <= '0;
      first_ff <= 1'b0;
      served_ff <= 1'b0;
    end
    else
    begin
      ph_cnt_ff <= ph_cnt_ff + CW'(1);
      if (accept)
        served_ff <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      wake_ff <= wdrs_pkg::WAKE_RST;
      reset_n_ff <= wdrs_pkg::RESET_N_RST;
    end
    else
    begin
      reset_n_ff <= (state_ff == wdrs_pkg::WDRS_RUN) && !missed &&
                    !hard_cause && supply_i.enable;
      // Wake is high in the first half of each period after the rise delay, until a service is accepted;
      // the phase is read before it advances, so both halves are HALF long
      wake_ff <= (state_ff == wdrs_pkg::WDRS_RUN) && !hard_cause &&
                 supply_i.enable && !first_ff && !accept && !served_ff &&
                 (ph_cnt_ff < HALF);
    end
  end

  assign reset_n_o = reset_n_ff;
  assign wake_o = wake_ff;

  // Run length of wake high, kept only for the duty check below
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || !wake_o)
      hi_cnt_ff <= '0;
    else
      hi_cnt_ff <= hi_cnt_ff + CW'(1);
  end

  sequence s_half_end;
    wake_o && (hi_cnt_ff == HALF - CW'(1)) ##1 !wake_o;
  endsequence

  AST_WAKE_LOW_IN_RESET: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !reset_n_o |-> !wake_o)
    else $error("Wake high during reset");

  AST_VIN_LOW_RESET: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    supply_i.vin_low |-> ##2 !reset_n_o)
    else $error("Low supply did not reset");

  AST_SERVE_WAKE_LOW: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    accept |=> !wake_o)
    else $error("Wake not forced low after service");

  AST_MISS_RESET: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    missed |=> !reset_n_o)
    else $error("Missed service gave no reset");

  AST_SHUTDOWN: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !supply_i.enable |-> ##2 (!reset_n_o && !wake_o))
    else $error("Shutdown not honoured");

  AST_BLANKING: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_ff == wdrs_pkg::WDRS_RUN) && !first_ff && !served_ff &&
    wdi_fall && (ph_cnt_ff < BLANK) |=> !served_ff)
    else $error("Service accepted in blanking");

  AST_ONE_SERVICE: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    served_ff && !period_end && supply_i.enable && !hard_cause &&
    (state_ff == wdrs_pkg::WDRS_RUN) |=> served_ff && !wake_o)
    else $error("Second service accepted");

  AST_UV_HOLD: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    $fell(supply_i.regulated_output_voltage_uv) && supply_i.enable && !supply_i.vin_low
    |-> ##1 !reset_n_o [*2])
    else $error("Reset released without delay");

  AST_WAKE_DUTY: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_ff == wdrs_pkg::WDRS_RUN) && !first_ff && !served_ff &&
    (ph_cnt_ff == HALF) |-> s_half_end)
    else $error("Wake high time not half a period");

endmodule : wdrs_supervisor
`default_nettype wire

// file: common/wdrs_pkg.sv
/*
  Package for the wake-up, watchdog and reset supervisor: timing constants,
  reset values, state enumeration and the input flag bundle.
  Assumes a 125 MHz system clock; durations other than the watchdog qualification times derive from the timing resistor.
*/
package wdrs_pkg;

  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CLK_PERIOD_NS = 8;

  // Timing resistor in ohms; coefficients in nanoseconds per ohm, times 100
  localparam longint unsigned TIMING_RESISTOR_OHM = 60_000;
  localparam longint unsigned WAKE_NS_PER_OHM_X100 = 39_500;
  localparam longint unsigned RST_DLY_NS_PER_OHM_X100 = 5_200;
  localparam longint unsigned RST_TO_WAKE_NS_PER_OHM_X100 = 19_600;

  localparam longint unsigned WAKE_PERIOD_NS =
    WAKE_NS_PER_OHM_X100 * TIMING_RESISTOR_OHM / 100;
  localparam longint unsigned RST_DELAY_NS =
    RST_DLY_NS_PER_OHM_X100 * TIMING_RESISTOR_OHM / 100;
  localparam longint unsigned RST_TO_WAKE_NS =
    RST_TO_WAKE_NS_PER_OHM_X100 * TIMING_RESISTOR_OHM / 100;

  // Wake-up period, reset delay and rise delay, in ticks of the timebase
  localparam int unsigned WAKE_PERIOD_CYC =
    int'(WAKE_PERIOD_NS / CLK_PERIOD_NS);
  localparam int unsigned RST_DELAY_CYC =
    int'((RST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned RST_TO_WAKE_CYC =
    int'(RST_TO_WAKE_NS / CLK_PERIOD_NS);

  // Watchdog qualification times
  localparam int unsigned BLANK_NS = 5_000;
  localparam int unsigned MIN_PULSE_NS = 1_000;
  localparam int unsigned BLANK_CYC =
    (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MIN_PULSE_CYC =
    (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic RESET_N_RST = 1'b0;
  localparam logic WAKE_RST = 1'b0;

  typedef enum logic [1:0] {
    WDRS_OFF,
    WDRS_HOLD,
    WDRS_DELAY,
    WDRS_RUN
  } wdrs_state_e;

  typedef struct packed {
    logic enable;
    logic regulated_output_voltage_in_reg;
    logic regulated_output_voltage_uv;
    logic vin_low;
  } wdrs_supply_s;

endpackage : wdrs_pkg

// file: verilog/wdrs_wdi_qual.sv
/*
  Watchdog service input qualifier: filters narrow pulses and emits one
  pulse per accepted falling edge. Assumes the input is synchronous.
*/
`timescale 1ns/10ps
`default_nettype none
module wdrs_wdi_qual #(
  parameter int unsigned MIN_CYC = wdrs_pkg::MIN_PULSE_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic watchdog_service_input_i,
  output logic fall_o
);

  localparam int W = $clog2(MIN_CYC + 1) + 1;

  logic [W-1:0] high_cnt_ff;
  logic level_ff;

  // A low after a high run shorter than the minimum is a glitch
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      high_cnt_ff <= '0;
      level_ff <= 1'b0;
    end
    else
    begin
      level_ff <= watchdog_service_input_i;
      if (!watchdog_service_input_i)
        high_cnt_ff <= '0;
      else if (high_cnt_ff < W'(MIN_CYC))
        high_cnt_ff <= high_cnt_ff + W'(1);
    end
  end

  assign fall_o = level_ff && !watchdog_service_input_i &&
                  (high_cnt_ff >= W'(MIN_CYC));

endmodule : wdrs_wdi_qual
`default_nettype wire

// file: test/wdrs_mcu_model.sv
/*
  Sleeping controller model: pulses the watchdog after each wake rise in modes 1 to 3.
  Assumes the bench picks the mode; output changes at the falling edge.
*/
`timescale 1ns/10ps
`default_nettype none
module wdrs_mcu_model (
  input wire logic clk_i,
  input wire logic wake_i,
  input wire logic [1:0] mode_i,
  output logic wdog_o
);
  logic wake_q;
  int cnt;
  int hs;
  int fe;
  // Mode 0 silent, 1 good, 2 falls in blanking, 3 too narrow
  always_comb
  begin
    hs = (mode_i == 2'h2) ? 0 : ((mode_i == 2'h3) ? 9 : 6);
    fe = (mode_i == 2'h2) ? 2 : 10;
  end
  // Idle level is low: a driven push-pull output, not a released line
  initial
  begin
    wdog_o = 1'b0;
    wake_q = 1'b0;
    cnt = 1000;
    forever
    begin
      @(negedge clk_i);
      cnt <= (wake_i && !wake_q) ? 0 : cnt + 1;
      wake_q <= wake_i;
      wdog_o <= (mode_i != 2'h0) && cnt >= hs && cnt < fe;
    end
  end
endmodule : wdrs_mcu_model
`default_nettype wire

// file: test/testbench.sv
/*
  Self-checking bench of the wake-up, watchdog and reset supervisor.
  Assumes shortened tick counts; the controller model services wake-ups in mode 1.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int WP = 200;
  localparam int RD = 20;
  localparam int RW = 50;
  localparam logic [4:0] ROWS [6] = '{5'h19, 5'h1c, 5'h1a, 5'h10, 5'h08,
    5'h19};
  logic sys_clk_i;
  logic rst_i;
  wdrs_pkg::wdrs_supply_s supply;
  logic wdog;
  logic reset_n;
  logic wake;
  logic [1:0] mode;
  int fails;
  int tests_run;
  int n;
  int bad_wake;
  wdrs_supervisor #(.WAKE_PERIOD_CYC(WP), .RST_DELAY_CYC(RD),
    .RST_TO_WAKE_CYC(RW), .BLANK_CYC(5), .MIN_PULSE_CYC(2)) dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .supply_i(supply),
    .watchdog_service_input_i(wdog), .reset_n_o(reset_n), .wake_o(wake));
  wdrs_mcu_model mcu (.clk_i(sys_clk_i), .wake_i(wake), .mode_i(mode),
    .wdog_o(wdog));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  // Wake must never be high while reset is asserted; sampled where settled
  always @(negedge sys_clk_i)
    if (!rst_i && reset_n === 1'b0 && wake !== 1'b0) bad_wake++;
  task chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t level %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task chk_rng(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi)
    begin
      fails++;
      $display("BAD %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_rng
  // Counts falling edges until the chosen output shows val, up to lim
  task wait_for(input bit sel, input logic val, input int lim);
    n = 0;
    while ((sel ? reset_n : wake) !== val && n < lim)
    begin
      @(negedge sys_clk_i);
      n++;
    end
  endtask : wait_for
  task give_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  initial
  begin
    #200000;
    fails++;
    give_verdict();
  end
  initial
  begin
    fails = 0;
    tests_run = 0;
    bad_wake = 0;
    rst_i = 1'b1;
    supply = '0;
    mode = 2'h1;
    repeat (20) @(negedge sys_clk_i);
    chk_bit(reset_n, 1'b0);
    rst_i = 1'b0;
    foreach (ROWS[i])
    begin
      supply = ROWS[i][4:1];
      repeat (40) @(negedge sys_clk_i);
      chk_bit(reset_n, ROWS[i][0]);
    end
    wait_for(0, 1'b1, WP + RW);
    wait_for(0, 1'b0, WP);
    chk_rng(n, 10, 14);
    repeat (3 * WP) @(negedge sys_clk_i);
    chk_bit(reset_n, 1'b1);
    supply.regulated_output_voltage_uv = 1'b1;
    repeat (10) @(negedge sys_clk_i);
    supply.regulated_output_voltage_uv = 1'b0;
    wait_for(1, 1'b1, 3 * RD);
    chk_rng(n, RD, RD + 4);
    wait_for(0, 1'b1, 3 * RW);
    chk_rng(n, RW - 1, RW + 3);
    mode = 2'h0;
    wait_for(0, 1'b0, WP);
    wait_for(0, 1'b1, 2 * WP);
    wait_for(0, 1'b0, WP);
    chk_rng(n, WP / 2 - 1, WP / 2 + 1);
    wait_for(1, 1'b0, WP);
    chk_rng(n, WP / 2 - 2, WP / 2 + 3);
    wait_for(1, 1'b1, 3 * RD);
    chk_rng(n, RD - 1, RD + 3);
    // Blanked and narrow services must both be refused
    for (int m = 2; m < 4; m++)
    begin
      mode = m[1:0];
      wait_for(1, 1'b0, 2 * WP + RW);
      chk_rng(n, WP + RW - 3, WP + RW + 1);
      wait_for(1, 1'b1, 3 * RD);
    end
    chk_rng(bad_wake, 0, 0);
    rst_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    chk_bit(reset_n, 1'b0);
    chk_bit(wake, 1'b0);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
